// File: rtl/shbp_irq_drv.sv
// Interrupt pin driver with polarity, buffer type and re-assert hold-off.
// Assumes the interrupt request arrives from logic on the same clock.
`timescale 1ns/100ps
module shbp_irq_drv (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic irq_req,
  input wire logic polarity_high,
  input wire logic open_drain,
  input wire logic [7:0] holdoff,
  output logic irq_o,
  output logic irq_oe_n
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic active;  // Interrupt currently asserted.
    logic [7:0] steps;  // Hold-off steps left.
    logic [3:0] sub;  // Cycles left in the current step.
    logic pin;  // Registered pin level.
    logic oe_n;  // Registered enable, low while driving.
  } shbp_irq_st_t;

  shbp_irq_st_t st_r;  // Registered state.
  shbp_irq_st_t st_nxt;  // Next state.
  logic assert_now;  // Interrupt level that will drive the pin.

  // Compute the next state; hold-off stops a fresh assertion until it runs out.
  always_comb begin
    st_nxt = st_r;
    assert_now = st_r.active;
    if (st_r.active && !irq_req) begin
      st_nxt.active = 1'b0;  // Deassert and start the hold-off.
      st_nxt.steps = holdoff;
      st_nxt.sub = shbp_pkg::HOLDOFF_UNIT_CYC_V;
    end else if (!st_r.active && irq_req && st_r.steps == 8'h00) begin
      st_nxt.active = 1'b1;  // Hold-off expired, so the request may pass.
    end else if (!st_r.active && st_r.steps != 8'h00) begin
      if (st_r.sub <= 4'h1) begin
        st_nxt.steps = st_r.steps - 8'h01;
        st_nxt.sub = shbp_pkg::HOLDOFF_UNIT_CYC_V;
      end else begin
        st_nxt.sub = st_r.sub - 4'h1;
      end
    end
    assert_now = st_nxt.active;
    if (open_drain) begin
      // Open-drain only pulls low when asserted, and floats otherwise.
      st_nxt.pin = 1'b0;
      st_nxt.oe_n = !assert_now;
    end else begin
      st_nxt.pin = polarity_high ? assert_now : !assert_now;
      st_nxt.oe_n = 1'b0;
    end
  end

  // Register the state; the clock enable freezes everything.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '{active: 1'b0, steps: shbp_pkg::HOLDOFF_RESET, sub: 4'h0,
                pin: 1'b0, oe_n: 1'b1};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign irq_o = st_r.pin;
  assign irq_oe_n = st_r.oe_n;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_od_never_drives_high;
    @(posedge clk) disable iff (!rst_n) (!irq_oe_n && $past(open_drain) && $past(ce)) |-> !irq_o;
  endproperty
  a_od_never_drives_high: assert property (p_od_never_drives_high)
    else $error("Open-drain interrupt pin drove high.");

  property p_holdoff_blocks;
    @(posedge clk) disable iff (!rst_n) (st_r.steps != 8'h00) |-> !st_r.active;
  endproperty
  a_holdoff_blocks: assert property (p_holdoff_blocks)
    else $error("Interrupt asserted during hold-off.");

  property p_pushpull_polarity;
    @(posedge clk) disable iff (!rst_n)
      ($past(ce) && !$past(open_drain) && $past(polarity_high) && $past(rst_n))
      |-> (irq_o == st_r.active);
  endproperty
  a_pushpull_polarity: assert property (p_pushpull_polarity)
    else $error("Interrupt pin polarity wrong.");

  c_irq_assert: cover property (@(posedge clk) disable iff (!rst_n) $rose(st_r.active));

endmodule

// File: rtl/shbp_pkg.sv
// Constants and types shared by the host bus port and its interrupt pin driver.
// Assumes a single 200 MHz system clock and a synchronous active-low reset.
//
// Notes on behaviour
// - Accept 32-bit or 16-bit host transfers, internal 32-bit.
// - Narrow bus halves are joined and split internally.
// - Big-endian option swaps byte lanes of register data.
// - Seven-bit word address selects registers or FIFOs.
// - Low read strobe marks a read access.
// - Strobes count only with chip select low.
// - Selected write strobe wakes device; writes only after a first read.
// - FIFO select routes access to FIFOs, ignoring high address.
// - Upper data pull-downs disabled in 32-bit mode.
// - Interrupt pin has selectable buffer type; polarity is selectable in push-pull mode only.
// - Interrupt pin may act as open-drain driver.
// - Programmable hold-off before interrupt re-asserts.
// - Host-initiated asynchronous cycles; device never masters.
// - Width strap latched at reset release; high is 32-bit.
package shbp_pkg;

  // ************************************************************
  // Widths and address decoding
  // ************************************************************
  localparam int ADDR_W = 7;  // Word address on lines 7 down to 1.
  localparam int DATA_W = 32;  // Internal data path width.
  localparam int HALF_W = 16;  // Narrow host bus width.
  localparam int FIFO_ADDR_LSB_KEEP = 2;  // Address bits kept when FIFO select is high.
  localparam logic [ADDR_W-1:0] FIFO_ADDR_MASK = 7'h03;  // Keeps lines 2 and 1 only.

  // ************************************************************
  // Reset values and timing
  // ************************************************************
  localparam logic BUS_WIDTH_RESET = 1'b1;  // Assume wide bus until the strap is caught.
  localparam logic [7:0] HOLDOFF_RESET = 8'h00;  // Hold-off counter after reset.
  localparam int HOLDOFF_UNIT_NS = 10;  // One hold-off step, in ns.
  localparam int CLK_PERIOD_NS = 5;  // System clock period in ns.
  localparam int HOLDOFF_UNIT_CYC = (HOLDOFF_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] HOLDOFF_UNIT_CYC_V = 4'(HOLDOFF_UNIT_CYC);  // Sized copy.

  // ************************************************************
  // Access states
  // ************************************************************
  typedef enum logic [1:0] {
    SHBP_IDLE = 2'b00,  // No strobe active.
    SHBP_READ = 2'b01,  // Read strobe held.
    SHBP_WRITE = 2'b10  // Write strobe held.
  } shbp_state_t;

endpackage

// File: rtl/shbp_port.sv
// Top of the SRAM-like host bus port: strobe capture, address decode, width
// conversion, byte swap and the interrupt pin.
// Assumes host pins are asynchronous; strobes and chip select are sampled through three flops.
`timescale 1ns/100ps
module shbp_port (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic [6:0] HOST_ADDR,
  input wire logic [31:0] HOST_DATA_I,
  output logic [31:0] HOST_DATA_O,
  output logic [31:0] HOST_DATA_OE_N,
  output logic UPPER_PULLDOWN_EN,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic CHIP_SELECT_N,
  input wire logic FIFO_SELECT,
  input wire logic BUS_WIDTH_STRAP,
  input wire logic BIG_ENDIAN,
  input wire logic IRQ_POLARITY_HIGH,
  input wire logic IRQ_OPEN_DRAIN,
  input wire logic [7:0] IRQ_HOLDOFF,
  input wire logic IRQ_REQ,
  output logic IRQ_O,
  output logic IRQ_OE_N,
  output logic REG_RD,
  output logic REG_WR,
  output logic FIFO_RD,
  output logic FIFO_WR,
  output logic [6:0] INT_ADDR,
  output logic [31:0] INT_WDATA,
  input wire logic [31:0] INT_RDATA,
  output logic WAKE,
  output logic WIDE_BUS
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [2:0] rd_s;  // Read strobe synchroniser, active high.
    logic [2:0] wr_s;  // Write strobe synchroniser, active high.
    logic [2:0] cs_s;  // Chip select synchroniser, active high.
    logic rd_q;  // Filtered read level.
    logic wr_q;  // Filtered write level.
    logic cs_q;  // Filtered chip select level.
    shbp_pkg::shbp_state_t state;  // Access state.
    logic strap_done;  // Width strap already caught.
    logic wide;  // Bus width, high for 32 bits.
    logic armed;  // A read has happened since reset.
    logic half_hi;  // Narrow mode: low half already taken.
    logic [15:0] low_half;  // Narrow mode: stored low half of a write.
    logic [31:0] rd_word;  // Narrow mode: word read on the low half.
    logic [31:0] dout;  // Data driven to the host.
    logic [31:0] doe_n;  // Data output enables, low while driving.
    logic reg_rd;  // Internal register read pulse.
    logic reg_wr;  // Internal register write pulse.
    logic fifo_rd;  // FIFO read pulse.
    logic fifo_wr;  // FIFO write pulse.
    logic [6:0] iaddr;  // Internal address.
    logic [31:0] iwdata;  // Internal write data.
    logic wake;  // Wake pulse.
    logic pd_en;  // Upper pull-down enable.
  } shbp_st_t;

  shbp_st_t st_r;  // Registered state.
  shbp_st_t st_nxt;  // Next state.

  // Swap byte lanes for big-endian hosts; register data only, FIFOs pass as is.
  function automatic logic [31:0] lane_swap(input logic [31:0] d, input logic en);
    lane_swap = en ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
  endfunction

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    logic rd_f;
    logic wr_f;
    logic cs_f;
    logic [6:0] addr;
    logic [31:0] word;
    rd_f = 1'b0;
    wr_f = 1'b0;
    cs_f = 1'b0;
    addr = 7'h00;
    word = 32'h0;
    st_nxt = st_r;
    st_nxt.reg_rd = 1'b0;
    st_nxt.reg_wr = 1'b0;
    st_nxt.fifo_rd = 1'b0;
    st_nxt.fifo_wr = 1'b0;
    st_nxt.wake = 1'b0;
    // Shift the pins in; only the second and third stages are compared.
    st_nxt.rd_s = {st_r.rd_s[1:0], !READ_STROBE_N};
    st_nxt.wr_s = {st_r.wr_s[1:0], !WRITE_STROBE_N};
    st_nxt.cs_s = {st_r.cs_s[1:0], !CHIP_SELECT_N};
    if (st_r.rd_s[2] == st_r.rd_s[1]) begin
      st_nxt.rd_q = st_r.rd_s[2];
    end
    if (st_r.wr_s[2] == st_r.wr_s[1]) begin
      st_nxt.wr_q = st_r.wr_s[2];
    end
    if (st_r.cs_s[2] == st_r.cs_s[1]) begin
      st_nxt.cs_q = st_r.cs_s[2];
    end
    rd_f = st_r.rd_q && st_r.cs_q;  // Strobes count only under chip select.
    wr_f = st_r.wr_q && st_r.cs_q;
    // The strap is caught once, in the first enabled cycle after release.
    if (!st_r.strap_done) begin
      st_nxt.wide = BUS_WIDTH_STRAP;
      st_nxt.strap_done = 1'b1;
    end
    st_nxt.pd_en = !st_nxt.wide;  // Pull-downs only on the narrow bus.
    // FIFO select discards the upper address lines.
    if (FIFO_SELECT) begin
      addr = HOST_ADDR & shbp_pkg::FIFO_ADDR_MASK;
    end else begin
      addr = HOST_ADDR;
    end
    // Narrow mode pairs on address line 1; the word index drops it.
    if (!st_r.wide) begin
      addr = {addr[6:1], 1'b0};
    end
    // The device only answers host strobes and never drives the strobes.
    case (st_r.state)
      shbp_pkg::SHBP_IDLE: begin
        if (rd_f) begin
          st_nxt.state = shbp_pkg::SHBP_READ;
          st_nxt.armed = 1'b1;  // First read unlocks writes.
          st_nxt.iaddr = addr;
          if (st_r.wide || !HOST_ADDR[0]) begin
            if (FIFO_SELECT) begin
              st_nxt.fifo_rd = 1'b1;
            end else begin
              st_nxt.reg_rd = 1'b1;
            end
          end
        end else if (wr_f) begin
          st_nxt.state = shbp_pkg::SHBP_WRITE;
          st_nxt.wake = 1'b1;  // Qualified write wakes the device.
          st_nxt.iaddr = addr;
          if (st_r.wide) begin
            word = HOST_DATA_I;
          end else if (!HOST_ADDR[0]) begin
            st_nxt.low_half = HOST_DATA_I[15:0];
            st_nxt.half_hi = 1'b1;
          end else begin
            word = {HOST_DATA_I[15:0], st_r.low_half};
          end
          if (st_r.armed && (st_r.wide || (HOST_ADDR[0] && st_r.half_hi))) begin
            st_nxt.half_hi = 1'b0;
            st_nxt.iwdata = FIFO_SELECT ? word : lane_swap(word, BIG_ENDIAN);
            if (FIFO_SELECT) begin
              st_nxt.fifo_wr = 1'b1;
            end else begin
              st_nxt.reg_wr = 1'b1;
            end
          end
        end
      end
      shbp_pkg::SHBP_READ: begin
        word = FIFO_SELECT ? INT_RDATA : lane_swap(INT_RDATA, BIG_ENDIAN);
        if (st_r.wide) begin
          st_nxt.dout = word;
          st_nxt.doe_n = 32'h0;
        end else begin
          if (!HOST_ADDR[0]) begin
            st_nxt.rd_word = word;
            st_nxt.dout = {16'h0, word[15:0]};
          end else begin
            st_nxt.dout = {16'h0, st_r.rd_word[31:16]};
          end
          st_nxt.doe_n = 32'hffff0000;
        end
        if (!rd_f) begin
          st_nxt.state = shbp_pkg::SHBP_IDLE;
          st_nxt.doe_n = 32'hffffffff;
        end
      end
      shbp_pkg::SHBP_WRITE: begin
        if (!wr_f) begin
          st_nxt.state = shbp_pkg::SHBP_IDLE;
        end
      end
      default: begin
        st_nxt.state = shbp_pkg::SHBP_IDLE;
      end
    endcase
  end

  // Register all state; reset takes constants only.
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      st_r <= '0;
      st_r.wide <= shbp_pkg::BUS_WIDTH_RESET;
      st_r.doe_n <= 32'hffffffff;
      st_r.state <= shbp_pkg::SHBP_IDLE;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // Interrupt pin
  // ************************************************************
  shbp_irq_drv u_irq (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .ce(CE),
    .irq_req(IRQ_REQ),
    .polarity_high(IRQ_POLARITY_HIGH),
    .open_drain(IRQ_OPEN_DRAIN),
    .holdoff(IRQ_HOLDOFF),
    .irq_o(IRQ_O),
    .irq_oe_n(IRQ_OE_N)
  );

  assign HOST_DATA_O = st_r.dout;
  assign HOST_DATA_OE_N = st_r.doe_n;
  assign UPPER_PULLDOWN_EN = st_r.pd_en;
  assign REG_RD = st_r.reg_rd;
  assign REG_WR = st_r.reg_wr;
  assign FIFO_RD = st_r.fifo_rd;
  assign FIFO_WR = st_r.fifo_wr;
  assign INT_ADDR = st_r.iaddr;
  assign INT_WDATA = st_r.iwdata;
  assign WAKE = st_r.wake;
  assign WIDE_BUS = st_r.wide;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_no_write_before_read;
    @(posedge CLK_SYS) disable iff (!RSTN) (REG_WR || FIFO_WR) |-> $past(st_r.armed);
  endproperty
  a_no_write_before_read: assert property (p_no_write_before_read)
    else $error("Write taken before any read.");

  property p_cs_gates;
    @(posedge CLK_SYS) disable iff (!RSTN) (REG_RD || FIFO_RD || WAKE) |-> $past(st_r.cs_q);
  endproperty
  a_cs_gates: assert property (p_cs_gates)
    else $error("Access taken without chip select.");

  property p_pulldown;
    @(posedge CLK_SYS) disable iff (!RSTN) st_r.strap_done && $past(st_r.strap_done)
      |-> (UPPER_PULLDOWN_EN == !WIDE_BUS);
  endproperty
  a_pulldown: assert property (p_pulldown)
    else $error("Pull-down state disagrees with bus width.");

  property p_fifo_addr;
    @(posedge CLK_SYS) disable iff (!RSTN) (FIFO_RD || FIFO_WR) |-> (INT_ADDR[6:2] == 5'h0);
  endproperty
  a_fifo_addr: assert property (p_fifo_addr)
    else $error("FIFO access kept upper address bits.");

  property p_wake_on_write;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && st_r.state == shbp_pkg::SHBP_IDLE && !st_r.rd_q && st_r.wr_q && st_r.cs_q)
      |=> WAKE;
  endproperty
  a_wake_on_write: assert property (p_wake_on_write)
    else $error("Qualified write did not wake the device.");

  // In narrow mode the upper lines are left to their pull-downs, never driven.
  property p_narrow_upper_float;
    @(posedge CLK_SYS) disable iff (!RSTN) !WIDE_BUS |-> (HOST_DATA_OE_N[31:16] == 16'hffff);
  endproperty
  a_narrow_upper_float: assert property (p_narrow_upper_float)
    else $error("Narrow bus drove the upper data lines.");

  // The width is caught once; a later change would garble every access.
  property p_strap_held;
    @(posedge CLK_SYS) disable iff (!RSTN) (st_r.strap_done && $past(st_r.strap_done))
      |-> $stable(WIDE_BUS);
  endproperty
  a_strap_held: assert property (p_strap_held)
    else $error("Bus width changed after it was latched.");

  // Once the filtered read strobe drops, the data lines are released next cycle.
  property p_read_release;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && st_r.state == shbp_pkg::SHBP_READ && !(st_r.rd_q && st_r.cs_q))
      |=> (HOST_DATA_OE_N == 32'hffffffff);
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("Data lines still driven after the read strobe ended.");

  // Each access raises at most one internal strobe, so FIFOs and registers never mix.
  property p_one_target;
    @(posedge CLK_SYS) disable iff (!RSTN) $onehot0({REG_RD, REG_WR, FIFO_RD, FIFO_WR});
  endproperty
  a_one_target: assert property (p_one_target)
    else $error("More than one internal strobe raised at once.");

  // The wake pulse lasts one enabled cycle; a held wake would look like many writes.
  property p_wake_pulse;
    @(posedge CLK_SYS) disable iff (!RSTN) (WAKE && CE) |=> !WAKE;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("Wake pulse lasted more than one cycle.");

  // Cover points for the main scenarios of the port.
  c_reg_read: cover property (@(posedge CLK_SYS) disable iff (!RSTN) REG_RD);
  c_reg_write: cover property (@(posedge CLK_SYS) disable iff (!RSTN) REG_WR);
  c_fifo_write: cover property (@(posedge CLK_SYS) disable iff (!RSTN) FIFO_WR && !WIDE_BUS);

endmodule

// File: tb/shbp_host_model.sv
// Behavioural host bus master that stands on the far side of the host bus port.
// Assumes bench tasks call access() and that the system clock paces the host.
`timescale 1ns/100ps
module shbp_host_model (
  input wire logic clk,
  input wire logic [31:0] dut_o,
  input wire logic [31:0] dut_oe_n,
  input wire logic pd_en,
  output logic [31:0] dq,
  output logic [6:0] addr,
  output logic rd_n,
  output logic wr_n,
  output logic cs_n
);
  // ************************************************************
  // Data wire
  // ************************************************************
  logic [31:0] hv = 32'h00000000;  // Last value the host put on the data lines.
  logic hen = 1'b0;  // High while the host drives the data lines.
  logic [31:0] idle_v;  // Level of lines that nobody drives.
  // Undriven lines show the inverse of the last value, or zero on the upper half while pd_en is high.
  assign idle_v = pd_en ? {16'h0000, ~hv[15:0]} : ~hv;
  // The port wins where it drives, then the host, then the idle level.
  assign dq = (~dut_oe_n & dut_o) | (dut_oe_n & (hen ? hv : idle_v));
  initial begin
    addr = 7'h00;
    rd_n = 1'b1;
    wr_n = 1'b1;
    cs_n = 1'b1;
  end
  // ************************************************************
  // Access
  // ************************************************************
  // There is no ready line, so strobes stay low and high ten cycles each.
  task automatic access(input logic is_rd, input logic sel, input logic [6:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    @(negedge clk);
    addr = a;
    cs_n = ~sel;
    hv = d;
    hen = ~is_rd;
    rd_n = ~is_rd;
    wr_n = is_rd;
    repeat (10) @(negedge clk);
    q = dq;
    rd_n = 1'b1;
    wr_n = 1'b1;
    hen = 1'b0;
    repeat (10) @(negedge clk);
    cs_n = 1'b1;
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the host bus port: table of wide accesses, then reset,
// narrow mode and interrupt pin cases. Assumes the host model file is compiled first.
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic fifo;
    logic be;
    logic rd;
    logic [6:0] addr;
    logic [31:0] data;
    logic [6:0] exp_addr;
    logic [31:0] exp_data;
  } shbp_row_t;
  // Register reads swap bytes in big-endian mode; FIFO traffic never does.
  localparam shbp_row_t ROWS [6] = '{
    '{1'b0, 1'b0, 1'b1, 7'h10, 32'h00000000, 7'h10, 32'h5ac31096},
    '{1'b0, 1'b0, 1'b0, 7'h24, 32'h12345678, 7'h24, 32'h12345678},
    '{1'b0, 1'b1, 1'b0, 7'h7f, 32'h12345678, 7'h7f, 32'h78563412},
    '{1'b0, 1'b1, 1'b1, 7'h01, 32'h00000000, 7'h01, 32'h9601c35a},
    '{1'b1, 1'b1, 1'b0, 7'h7e, 32'ha1b2c3d4, 7'h02, 32'ha1b2c3d4},
    '{1'b1, 1'b1, 1'b1, 7'h55, 32'h00000000, 7'h01, 32'h5ac30196}};
  logic clk = 1'b0;
  logic ce = 1'b1;  // Clock enable, dropped once to check that state freezes.
  logic rstn = 1'b0;
  logic strap = 1'b1;
  logic big = 1'b0;
  logic fifo = 1'b0;
  logic pol = 1'b1;
  logic od = 1'b0;
  logic [7:0] holdoff = 8'h00;
  logic irq_req = 1'b0;
  logic [31:0] dq, d_o, d_oe_n, int_wdata, int_rdata, q;
  logic [6:0] haddr, int_addr;
  logic rd_n, wr_n, cs_n, pd, irq_o, irq_oe_n, wide;
  logic reg_rd, reg_wr, fifo_rd, fifo_wr, wake;
  logic [3:0] n_rrd, n_rwr, n_frd, n_fwr, n_wake;  // Pulses seen since the last clear.
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  // The internal side answers with a word that carries its own address.
  assign int_rdata = {8'h5a, 8'hc3, 1'b0, int_addr, 8'h96};
  always #2.5 clk = ~clk;
  shbp_host_model HOST (.clk(clk), .dut_o(d_o), .dut_oe_n(d_oe_n), .pd_en(pd), .dq(dq),
    .addr(haddr), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n));
  shbp_port DUT (.CLK_SYS(clk), .RSTN(rstn), .CE(ce), .HOST_ADDR(haddr),
    .HOST_DATA_I(dq), .HOST_DATA_O(d_o), .HOST_DATA_OE_N(d_oe_n), .UPPER_PULLDOWN_EN(pd),
    .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .CHIP_SELECT_N(cs_n), .FIFO_SELECT(fifo),
    .BUS_WIDTH_STRAP(strap), .BIG_ENDIAN(big), .IRQ_POLARITY_HIGH(pol),
    .IRQ_OPEN_DRAIN(od), .IRQ_HOLDOFF(holdoff), .IRQ_REQ(irq_req), .IRQ_O(irq_o),
    .IRQ_OE_N(irq_oe_n), .REG_RD(reg_rd), .REG_WR(reg_wr), .FIFO_RD(fifo_rd),
    .FIFO_WR(fifo_wr), .INT_ADDR(int_addr), .INT_WDATA(int_wdata),
    .INT_RDATA(int_rdata), .WAKE(wake), .WIDE_BUS(wide));
  // ************************************************************
  // Pulse counting and timeout
  // ************************************************************
  // Pulses last one cycle, so they are counted on every rising edge.
  always @(posedge clk) begin
    n_rrd <= n_rrd + 4'(reg_rd);
    n_rwr <= n_rwr + 4'(reg_wr);
    n_frd <= n_frd + 4'(fifo_rd);
    n_fwr <= n_fwr + 4'(fifo_wr);
    n_wake <= n_wake + 4'(wake);
    cyc <= cyc + 1;
    // About 430 cycles are needed; the ceiling leaves ample margin.
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic clr();
    @(negedge clk);
    {n_rrd, n_rwr, n_frd, n_fwr, n_wake} = 20'h00000;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic s);
    @(negedge clk);
    rstn = 1'b0;
    strap = s;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  // Sets the interrupt request and checks the pin level and enable as a pair.
  task automatic irq_step(input logic req, input logic [1:0] exp);
    irq_req = req;
    repeat (6) @(negedge clk);
    chk({30'h0, irq_o, irq_oe_n}, {30'h0, exp});
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {n_rrd, n_rwr, n_frd, n_fwr, n_wake} = 20'h00000;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    chk(d_oe_n, 32'hffffffff);
    chk({31'h0, wide}, 32'h1);
    chk({31'h0, pd}, 32'h0);
    $display("TEST reset done");
    // Unselected strobes must leave no trace, not even a wake.
    clr();
    HOST.access(1'b1, 1'b0, 7'h10, 32'h0, q);
    HOST.access(1'b0, 1'b0, 7'h10, 32'h11111111, q);
    chk({12'h0, n_rrd, n_rwr, n_frd, n_fwr, n_wake}, 32'h0);
    // A write before any read wakes the device but is dropped.
    clr();
    HOST.access(1'b0, 1'b1, 7'h08, 32'hdeadbeef, q);
    chk({28'h0, n_rwr}, 32'h0);
    chk({28'h0, n_wake}, 32'h1);
    $display("TEST refusal done");
    foreach (ROWS[i]) begin
      fifo = ROWS[i].fifo;
      big = ROWS[i].be;
      clr();
      HOST.access(ROWS[i].rd, 1'b1, ROWS[i].addr, ROWS[i].data, q);
      chk({25'h0, int_addr}, {25'h0, ROWS[i].exp_addr});
      chk(ROWS[i].rd ? q : int_wdata, ROWS[i].exp_data);
      chk({16'h0, n_rrd, n_rwr, n_frd, n_fwr}, {19'h0, ROWS[i].rd & ~ROWS[i].fifo,
        3'h0, ~ROWS[i].rd & ~ROWS[i].fifo, 3'h0, ROWS[i].rd & ROWS[i].fifo,
        3'h0, ~ROWS[i].rd & ROWS[i].fifo});
      chk({28'h0, n_wake}, {31'h0, ~ROWS[i].rd});
    end
    $display("TEST wide table done");
    // Narrow bus: low half first, the word moves on the pair.
    fifo = 1'b0;
    big = 1'b0;
    do_reset(1'b0);
    chk({31'h0, wide}, 32'h0);
    chk({31'h0, pd}, 32'h1);
    clr();
    HOST.access(1'b1, 1'b1, 7'h20, 32'h0, q);
    chk({16'h0, q[15:0]}, 32'h00002096);
    chk({28'h0, n_rrd}, 32'h1);
    HOST.access(1'b1, 1'b1, 7'h21, 32'h0, q);
    chk({16'h0, q[15:0]}, 32'h00005ac3);
    clr();
    HOST.access(1'b0, 1'b1, 7'h30, 32'h0000beef, q);
    chk({28'h0, n_rwr}, 32'h0);
    HOST.access(1'b0, 1'b1, 7'h31, 32'h0000cafe, q);
    chk({28'h0, n_rwr}, 32'h1);
    chk(int_wdata, 32'hcafebeef);
    chk({25'h0, int_addr}, 32'h30);
    // Narrow FIFO write: upper address dropped, halves paired, no byte swap.
    fifo = 1'b1;
    big = 1'b1;
    clr();
    HOST.access(1'b0, 1'b1, 7'h7c, 32'h00001234, q);
    HOST.access(1'b0, 1'b1, 7'h7d, 32'h0000abcd, q);
    chk({28'h0, n_fwr}, 32'h1);
    chk(int_wdata, 32'habcd1234);
    chk({25'h0, int_addr}, 32'h0);
    fifo = 1'b0;
    big = 1'b0;
    $display("TEST narrow done");
    // Interrupt pin: both polarities push-pull, then open drain.
    irq_step(1'b1, 2'b10);
    irq_step(1'b0, 2'b00);
    pol = 1'b0;
    irq_step(1'b1, 2'b00);
    irq_step(1'b0, 2'b10);
    pol = 1'b1;
    od = 1'b1;
    irq_step(1'b1, 2'b00);
    irq_step(1'b0, 2'b01);
    // Hold-off of ten steps blocks a quick re-assert for twenty cycles.
    od = 1'b0;
    holdoff = 8'h0a;
    irq_step(1'b1, 2'b10);
    irq_req = 1'b0;
    repeat (4) @(negedge clk);
    irq_req = 1'b1;
    repeat (8) @(negedge clk);
    chk({31'h0, irq_o}, 32'h0);
    repeat (30) @(negedge clk);
    chk({31'h0, irq_o}, 32'h1);
    $display("TEST interrupt done");
    // With the clock enable low the pin holds, even when the request drops.
    ce = 1'b0;
    irq_req = 1'b0;
    repeat (6) @(negedge clk);
    chk({31'h0, irq_o}, 32'h1);
    ce = 1'b1;
    repeat (6) @(negedge clk);
    chk({31'h0, irq_o}, 32'h0);
    $display("TEST clock enable done");
    wrap_up();
  end
endmodule
